/* File: ccos_consts.vh */
// constants for the capture/compare output and shutdown control block
// assumes a 16-bit register map reached over classic wishbone, byte addressed
`ifndef CCOS_CONSTS_VH
`define CCOS_CONSTS_VH
// register byte offsets
`define CCOS_ADR_GATE      4'h0
`define CCOS_ADR_OEN       4'h4
`define CCOS_ADR_DT        4'h8
`define CCOS_ADR_MODE      4'hC
// gate register fields
`define CCOS_GATE_RSEN     15
`define CCOS_GATE_GM       14
`define CCOS_GATE_SW       12
`define CCOS_GATE_MASK     16'hD0FF
// output enable register fields
`define CCOS_OEN_SYNC      15
`define CCOS_OEN_MASK      16'hBFDF
`define CCOS_OEN_RST       16'h0100
// dead time register
`define CCOS_DT_MASK       16'h003F
// mode register fields
`define CCOS_MODE_HOLD     15
`define CCOS_MODE_POLARITY_GROUP_ACE   5
`define CCOS_MODE_POLARITY_GROUP_BDF   4
`define CCOS_MODE_MASK     16'hF73F
// capture gate modes
`define CCOS_GSM_LEVEL     2'b00
`define CCOS_GSM_RISE      2'b01
`define CCOS_GSM_FALL      2'b10
// aux output select
`define CCOS_AUX_OFF       2'b00
`define CCOS_AUX_ROLL      2'b01
`define CCOS_AUX_MODE      2'b10
`define CCOS_AUX_EVT       2'b11
// shutdown pin states
`define CCOS_PSS_ACTIVE    2'b11
`define CCOS_PSS_INACTIVE  2'b10
`endif

/* File: ccos_top.v */
// output steering, shutdown and capture gating for a capture/compare/pwm unit
// assumes a time base outside that supplies rollover, trigger and pwm signals on clk_i
`include "ccos_consts.vh"
module ccos_top #(
    parameter FULL = 1,                    // full-featured variant
    parameter PINS64 = 0                   // 64-pin part
) (
    input  wire        clk_i,              // module clock
    input  wire        rst_i,              // synchronous reset, high
    input  wire        wb_cyc_i,           // wishbone cycle
    input  wire        wb_stb_i,           // wishbone strobe
    input  wire        wb_we_i,            // wishbone write
    input  wire [3:0]  wb_adr_i,           // byte address
    input  wire [1:0]  wb_sel_i,           // byte selects
    input  wire [15:0] wb_dat_i,           // write data
    output reg  [15:0] wb_dat_o,           // read data
    output reg         wb_ack_o,           // acknowledge
    input  wire [7:0]  shutdown_src_i,     // async shutdown sources
    input  wire        tb_roll_i,          // time base reset/rollover pulse
    input  wire        trigger_enable_i,   // triggered time base selected
    input  wire        triggered_i,        // time base has been triggered
    input  wire        oneshot_start_i,    // one-shot trigger pulse
    input  wire        pwm_i,              // raw pwm/compare signal
    input  wire        mode_sig_i,         // mode-defined aux signal
    input  wire        cc_event_i,         // capture/compare event pulse
    input  wire        timer_mode_i,       // module in timer mode
    input  wire        capture_input_pin_i,// capture pin, async
    input  wire [2:0]  cmp_i,              // comparator outputs, async
    input  wire [3:0]  logic_cell_i,       // logic-cell outputs, async
    input  wire        cap_gate_i,         // capture gating source, async
    input  wire        cap_gate_arm_i,     // arm one-shot gating, pulse
    output reg  [5:0]  compare_output_pin_o,   // pins a..f level
    output reg  [5:0]  compare_output_pin_oe_n_o, // low while driven
    output reg  [5:0]  output_pin_enables_o,  // pin ownership a..f
    output reg         aux_o,              // auxiliary output
    output reg         capture_sig_o,      // gated capture input
    output reg         capture_disable_o,  // capture disable status
    output reg         oneshot_active_o,   // extended one-shot window
    output reg         shutdown_event_status_o // shutdown in progress
);
    // ****************************************
    // registers
    // ****************************************
    reg  [15:0] gate_r, oen_r, dt_r, mode_r;
    reg  [5:0]  oen_act_r;
    reg  [1:0]  clr_req_r;
    wire [15:0] oen_msk = `CCOS_OEN_MASK & (FULL ? 16'hFFFF : 16'hC1FF)
                          & (PINS64 ? 16'hC3FF : 16'hFFFF);
    wire [15:0] dt_msk   = FULL ? `CCOS_DT_MASK : 16'h0000;
    wire [15:0] mode_msk = `CCOS_MODE_MASK & (FULL ? 16'hFFFF : 16'hF82C);
    wire        acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr  = acc & wb_we_i;
    wire [15:0] bm  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    always @(posedge clk_i) begin
        if (rst_i) begin
            gate_r <= 16'h0000;
            oen_r <= `CCOS_OEN_RST;
            dt_r <= 16'h0000;
            mode_r <= 16'h0000;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 16'h0000;
        end else begin
            wb_ack_o <= acc;
            if (wr && wb_adr_i == `CCOS_ADR_GATE)
                gate_r <= ((wb_dat_i & bm) | (gate_r & ~bm)) & `CCOS_GATE_MASK;
            if (wr && wb_adr_i == `CCOS_ADR_OEN)
                oen_r <= ((wb_dat_i & bm) | (oen_r & ~bm)) & oen_msk;
            if (wr && wb_adr_i == `CCOS_ADR_DT)
                dt_r <= ((wb_dat_i & bm) | (dt_r & ~bm)) & dt_msk;
            if (wr && wb_adr_i == `CCOS_ADR_MODE)
                mode_r <= ((wb_dat_i & bm) | (mode_r & ~bm)) & mode_msk;
            if (acc && !wb_we_i) begin
                case (wb_adr_i)
                    `CCOS_ADR_GATE: wb_dat_o <= gate_r;
                    `CCOS_ADR_OEN:  wb_dat_o <= oen_r;
                    `CCOS_ADR_DT:   wb_dat_o <= dt_r;
                    `CCOS_ADR_MODE: wb_dat_o <= mode_r;
                    default:        wb_dat_o <= 16'h0000;
                endcase
            end
        end
    end
    // ****************************************
    // input synchronisers
    // ****************************************
    reg [16:0] s1_r, s2_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 17'h0_0000;
            s2_r <= 17'h0_0000;
        end else begin
            s1_r <= {shutdown_src_i, capture_input_pin_i, cmp_i, logic_cell_i, cap_gate_i};
            s2_r <= s1_r;
        end
    end
    wire [7:0] src_s  = s2_r[16:9];
    wire       gate_s = s2_r[0];
    // ****************************************
    // shutdown
    // ****************************************
    wire sd_req = (|(src_s & gate_r[7:0])) | gate_r[`CCOS_GATE_SW];
    reg  sd_r;
    always @(posedge clk_i) begin
        if (rst_i)
            sd_r <= 1'b0;
        else if (sd_req && (!gate_r[`CCOS_GATE_GM] || tb_roll_i))
            sd_r <= 1'b1;
        else if (gate_r[`CCOS_GATE_RSEN] && tb_roll_i)
            sd_r <= 1'b0;
        else if (clr_req_r[0])
            sd_r <= 1'b0;
    end
    // software clear: a gate write with no source enabled and the software bit left low
    always @(posedge clk_i) begin
        if (rst_i)
            clr_req_r <= 2'b00;
        else
            clr_req_r <= {1'b0, wr && wb_adr_i == `CCOS_ADR_GATE && wb_sel_i[0] && wb_dat_i[7:0] == 8'h00
                          && !(wb_sel_i[1] ? wb_dat_i[`CCOS_GATE_SW] : gate_r[`CCOS_GATE_SW])};
    end
    // ****************************************
    // output enable steering
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i)
            oen_act_r <= 6'b00_0001;
        else if (!oen_r[`CCOS_OEN_SYNC] || tb_roll_i)
            oen_act_r <= oen_r[13:8];
    end
    // ****************************************
    // one-shot extension
    // ****************************************
    reg [2:0] os_cnt_r;
    reg       os_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            os_cnt_r <= 3'h0;
            os_r <= 1'b0;
        end else if (oneshot_start_i) begin
            os_cnt_r <= mode_r[14:12];
            os_r <= 1'b1;
        end else if (os_r && tb_roll_i) begin
            if (os_cnt_r == 3'h0)
                os_r <= 1'b0;
            else
                os_cnt_r <= os_cnt_r - 3'h1;
        end
    end
    // ****************************************
    // dead time
    // ****************************************
    reg [5:0] dt_cnt_r;
    reg       pwm_d_r, pa_r, pb_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            dt_cnt_r <= 6'h00;
            pwm_d_r <= 1'b0;
            pa_r <= 1'b0;
            pb_r <= 1'b0;
        end else begin
            pwm_d_r <= pwm_i;
            if (dt_r[5:0] == 6'h00) begin
                pa_r <= pwm_i;
                pb_r <= ~pwm_i;
            end else if (pwm_i != pwm_d_r) begin
                dt_cnt_r <= dt_r[5:0];
                pa_r <= 1'b0;
                pb_r <= 1'b0;
            end else if (dt_cnt_r > 6'h01) begin
                dt_cnt_r <= dt_cnt_r - 6'h01;
            end else begin
                dt_cnt_r <= 6'h00;
                pa_r <= pwm_d_r;
                pb_r <= ~pwm_d_r;
            end
        end
    end
    // ****************************************
    // output pattern
    // ****************************************
    reg [5:0] pat;
    reg       scan_r;
    always @(posedge clk_i) begin
        if (rst_i)
            scan_r <= 1'b0;
        else if (tb_roll_i)
            scan_r <= ~scan_r;
    end
    always @* begin
        case (mode_r[10:8])
            3'b000:  pat = {6{pa_r}};
            3'b001:  pat = {3{scan_r & pa_r, ~scan_r & pa_r}};
            3'b010:  pat = {3{pb_r, pa_r}};
            3'b100:  pat = {4'h0, pa_r, 1'b1};
            3'b101:  pat = {4'h0, 1'b1, pa_r};
            3'b110:  pat = {4'h0, scan_r & pa_r, ~scan_r & pa_r};
            default: pat = 6'h00;
        endcase
    end
    wire       hold = mode_r[`CCOS_MODE_HOLD] & trigger_enable_i & ~triggered_i;
    wire [5:0] pol  = {3{mode_r[`CCOS_MODE_POLARITY_GROUP_BDF], mode_r[`CCOS_MODE_POLARITY_GROUP_ACE]}};
    wire [5:0] pss_act = {3{mode_r[1], mode_r[3]}};
    wire [5:0] pss_lvl = {3{mode_r[0], mode_r[2]}};
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            compare_output_pin_o <= 6'h00;
            compare_output_pin_oe_n_o <= 6'h3F;
            output_pin_enables_o <= 6'h00;
        end else begin
            output_pin_enables_o <= oen_act_r;
            for (i = 0; i < 6; i = i + 1) begin
                if (!oen_act_r[i] || hold) begin
                    compare_output_pin_oe_n_o[i] <= 1'b1;
                    compare_output_pin_o[i] <= 1'b0;
                end else if (sd_r) begin
                    compare_output_pin_oe_n_o[i] <= ~pss_act[i];
                    compare_output_pin_o[i] <= pss_act[i] & (pss_lvl[i] ^ pol[i]);
                end else begin
                    compare_output_pin_oe_n_o[i] <= 1'b0;
                    compare_output_pin_o[i] <= pat[i] ^ pol[i];
                end
            end
        end
    end
    // ****************************************
    // capture path
    // ****************************************
    reg gate_d_r, armed_r, csrc;
    always @* begin
        case (oen_r[2:0])
            3'b000:  csrc = s2_r[8];
            3'b001:  csrc = s2_r[5];
            3'b010:  csrc = s2_r[6];
            3'b011:  csrc = s2_r[7];
            3'b100:  csrc = s2_r[1];
            3'b101:  csrc = s2_r[2];
            3'b110:  csrc = s2_r[3];
            default: csrc = s2_r[4];
        endcase
    end
    wire gated_sd = sd_req & gate_r[`CCOS_GATE_SW];
    always @(posedge clk_i) begin
        if (rst_i) begin
            gate_d_r <= 1'b0;
            armed_r <= 1'b0;
            capture_disable_o <= 1'b0;
            capture_sig_o <= 1'b0;
            aux_o <= 1'b0;
            oneshot_active_o <= 1'b0;
            shutdown_event_status_o <= 1'b0;
        end else begin
            gate_d_r <= gate_s;
            shutdown_event_status_o <= sd_r;
            oneshot_active_o <= os_r;
            case (oen_r[7:6])
                `CCOS_GSM_LEVEL: capture_disable_o <= ~gate_s | gated_sd;
                `CCOS_GSM_RISE: if (armed_r && gate_s && !gate_d_r) begin
                    capture_disable_o <= 1'b0;
                    armed_r <= 1'b0;
                end
                `CCOS_GSM_FALL: if (armed_r && !gate_s && gate_d_r) begin
                    capture_disable_o <= 1'b1;
                    armed_r <= 1'b0;
                end
                default: capture_disable_o <= capture_disable_o;
            endcase
            if (cap_gate_arm_i)
                armed_r <= 1'b1;
            capture_sig_o <= csrc & ~capture_disable_o;
            case (oen_r[4:3])
                `CCOS_AUX_OFF:  aux_o <= 1'b0;
                `CCOS_AUX_ROLL: aux_o <= tb_roll_i;
                `CCOS_AUX_MODE: aux_o <= mode_sig_i;
                default:        aux_o <= cc_event_i & ~timer_mode_i;
            endcase
        end
    end
endmodule // ccos_top

/* File: ccos_load_model.sv */
// load model for the pins of the output and shutdown control block
// assumes the block's pin level and active-low drive enable per pin
module ccos_load_model (
    input  wire logic       clk_i,  // clock
    input  wire logic [5:0] drv_i,  // pin levels
    input  wire logic [5:0] oe_n_i, // low while driven
    output logic      [5:0] pad_o   // level seen by the load
);
    // ****************************************
    // released pins float: show the inverse
    // ****************************************
    logic [5:0] last_r;
    always_ff @(posedge clk_i) begin
        last_r <= (drv_i & ~oe_n_i) | (last_r & oe_n_i);
    end
    assign pad_o = (drv_i & ~oe_n_i) | (~last_r & oe_n_i);
endmodule // ccos_load_model

/* File: ccos_properties.sv */
// assertions on the ports of the output and shutdown control block
// assumes whole-word wishbone writes; bound from the bench top
module ccos_checker (
    input wire logic clk_i,                           // clock
    input wire logic rst_i,                           // reset
    input wire logic wb_cyc_i,                        // cycle
    input wire logic wb_stb_i,                        // strobe
    input wire logic wb_we_i,                         // write
    input wire logic [3:0] wb_adr_i,                  // address
    input wire logic [15:0] wb_dat_i,                 // write data
    input wire logic wb_ack_o,                        // ack
    input wire logic [7:0] shutdown_src_i,            // sources
    input wire logic tb_roll_i,                       // rollover
    input wire logic trigger_enable_i,                // trig mode
    input wire logic triggered_i,                     // triggered
    input wire logic [5:0] compare_output_pin_o,      // pins
    input wire logic [5:0] compare_output_pin_oe_n_o, // drive
    input wire logic [5:0] output_pin_enables_o,      // ownership
    input wire logic aux_o,                           // aux
    input wire logic shutdown_event_status_o          // shut down
);
    // ****************************************
    // register shadows and age counters
    // ****************************************
    logic [15:0] o_r, m_r;
    logic [5:0]  ra_r, sa_r;
    logic        wr;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            o_r <= 16'h0100;
            m_r <= 16'h0000;
        end else if (wr && wb_adr_i == 4'h4) begin
            o_r <= wb_dat_i;
        end else if (wr && wb_adr_i == 4'hC) begin
            m_r <= wb_dat_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || tb_roll_i || wr) ra_r <= 6'h00;
        else if (ra_r != 6'h3F) ra_r <= ra_r + 6'h01;
        if (rst_i || wr || |shutdown_src_i) sa_r <= 6'h00;
        else if (sa_r != 6'h3F) sa_r <= sa_r + 6'h01;
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    oen_direct_a: assert property (wr && wb_adr_i == 4'h4 && !wb_dat_i[15] |=> ##[0:1]
        output_pin_enables_o == o_r[13:8]) else $error("enables not applied");
    oen_synced_a: assert property ($changed(output_pin_enables_o) && o_r[15] |-> ra_r <= 3)
        else $error("enables changed off rollover");
    aux_off_a: assert property (o_r[4:3] == 2'b00 [*2] |-> !aux_o) else $error("aux active when off");
    aux_roll_a: assert property (o_r[4:3] == 2'b01 && tb_roll_i |-> ##[1:2] aux_o)
        else $error("aux missed rollover");
    status_clear_a: assert property ($fell(shutdown_event_status_o) |-> ra_r <= 5)
        else $error("status cleared without cause");
    status_set_a: assert property ($rose(shutdown_event_status_o) |-> sa_r <= 40)
        else $error("status set without cause");
    pss_inactive_a: assert property (shutdown_event_status_o [*2] ##0 (m_r[3:2] == 2'b10 && output_pin_enables_o[0])
        |-> !compare_output_pin_oe_n_o[0] && compare_output_pin_o[0] == m_r[5]) else $error("pin not inactive");
    pss_float_a: assert property (shutdown_event_status_o [*2] ##0 !m_r[3] |-> compare_output_pin_oe_n_o[0])
        else $error("pin driven in float state");
    trig_hold_a: assert property ((m_r[15] && trigger_enable_i && !triggered_i) [*3]
        |-> compare_output_pin_oe_n_o == 6'h3F) else $error("pins driven before trigger");
    cover property ($rose(shutdown_event_status_o));
    cover property (aux_o);
    cover property ($changed(output_pin_enables_o) && o_r[15]);
endmodule // ccos_checker

/* File: ccos_top_test.sv */
// self-checking bench for the output and shutdown control block
// assumes the block's wishbone map and a load model on the pins
`include "ccos_consts.vh"
module ccos_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tb_roll_i, trigger_enable_i, triggered_i;
    logic oneshot_start_i, pwm_i, mode_sig_i, cc_event_i, timer_mode_i, capture_input_pin_i, cap_gate_i;
    logic cap_gate_arm_i, aux_o, capture_sig_o, capture_disable_o, oneshot_active_o, shutdown_event_status_o;
    logic [3:0]  wb_adr_i, logic_cell_i;
    logic [1:0]  wb_sel_i;
    logic [15:0] wb_dat_i, wb_dat_o, d;
    logic [7:0]  shutdown_src_i;
    logic [2:0]  cmp_i;
    logic [5:0]  compare_output_pin_o, compare_output_pin_oe_n_o, output_pin_enables_o, pad;
    logic [15:0] exp_q[$];
    logic [3:0]  adr[4] = '{`CCOS_ADR_GATE, `CCOS_ADR_OEN, `CCOS_ADR_DT, `CCOS_ADR_MODE};
    logic [15:0] msk[4] = '{`CCOS_GATE_MASK, `CCOS_OEN_MASK, `CCOS_DT_MASK, `CCOS_MODE_MASK};
    int bad_count = 0;
    int n_compared = 0;
    ccos_top i_dut (.*);
    ccos_load_model i_load (.clk_i(clk_i), .drv_i(compare_output_pin_o), .oe_n_i(compare_output_pin_oe_n_o), .pad_o(pad));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [15:0] dv);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dv;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) bad_count++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 16'h0000);
    endtask
    task automatic roll();
        tb_roll_i <= 1'b1;
        @(posedge clk_i);
        tb_roll_i <= 1'b0;
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ****************************************
    // clock, monitor, random inputs, watchdog
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) chk(wb_dat_o, exp_q.pop_front());
    end
    always @(posedge clk_i) begin
        {pwm_i, mode_sig_i, cc_event_i, timer_mode_i, capture_input_pin_i, cmp_i, logic_cell_i, cap_gate_i} <= 13'($urandom);
    end
    initial begin
        cyc(20000);
        bad_count++;
        final_report();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, tb_roll_i, trigger_enable_i, triggered_i, oneshot_start_i} = 8'h80;
        {pwm_i, mode_sig_i, cc_event_i, timer_mode_i, capture_input_pin_i, cmp_i, logic_cell_i, cap_gate_i} = '0;
        {wb_adr_i, wb_dat_i, shutdown_src_i, cap_gate_arm_i} = '0;
        wb_sel_i = 2'b11;
        void'($urandom(32'he93f03c0));
        cyc(5);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) rd(adr[i], i == 1 ? `CCOS_OEN_RST : 16'h0000);
        rd(4'h2, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            wb(1'b1, adr[i], d);
            rd(adr[i], d & msk[i]);
            wb(1'b1, adr[i], i == 1 ? `CCOS_OEN_RST : 16'h0000);
        end
        wb(1'b1, `CCOS_ADR_MODE, 16'h0028);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, `CCOS_ADR_GATE, 16'h0001 << i);
            shutdown_src_i <= 8'h01 << ((i + 1) % 8);
            cyc(8);
            chk(shutdown_event_status_o, 16'h0000);
            shutdown_src_i <= 8'h01 << i;
            cyc(8);
            chk(shutdown_event_status_o, 16'h0001);
            chk(pad[0], 16'h0001);
            shutdown_src_i <= 8'h00;
            cyc(4);
            roll();
            cyc(4);
            chk(shutdown_event_status_o, 16'h0001);
            wb(1'b1, `CCOS_ADR_GATE, 16'h0000);
            cyc(4);
            chk(shutdown_event_status_o, 16'h0000);
        end
        wb(1'b1, `CCOS_ADR_GATE, 16'hC040);
        shutdown_src_i <= 8'h40;
        cyc(8);
        chk(shutdown_event_status_o, 16'h0000);
        roll();
        cyc(4);
        chk(shutdown_event_status_o, 16'h0001);
        shutdown_src_i <= 8'h00;
        cyc(8);
        chk(shutdown_event_status_o, 16'h0001);
        roll();
        cyc(4);
        chk(shutdown_event_status_o, 16'h0000);
        wb(1'b1, `CCOS_ADR_MODE, 16'h0000);
        wb(1'b1, `CCOS_ADR_GATE, 16'h5000);
        cyc(8);
        chk(shutdown_event_status_o, 16'h0000);
        roll();
        cyc(4);
        chk(shutdown_event_status_o, 16'h0001);
        chk(compare_output_pin_oe_n_o[0], 16'h0001);
        wb(1'b1, `CCOS_ADR_GATE, 16'h0000);
        wb(1'b1, `CCOS_ADR_OEN, 16'h8300);
        cyc(4);
        chk(output_pin_enables_o, 16'h0001);
        roll();
        cyc(3);
        chk(output_pin_enables_o, 16'h0003);
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `CCOS_ADR_OEN, 16'h0100 | (16'(c) << 3));
            roll();
            cyc(3);
        end
        wb(1'b1, `CCOS_ADR_MODE, 16'h8000);
        trigger_enable_i <= 1'b1;
        cyc(6);
        chk(compare_output_pin_oe_n_o[0], 16'h0001);
        triggered_i <= 1'b1;
        cyc(6);
        chk(compare_output_pin_oe_n_o[0], 16'h0000);
        wb(1'b1, `CCOS_ADR_MODE, 16'h2000);
        oneshot_start_i <= 1'b1;
        @(posedge clk_i);
        oneshot_start_i <= 1'b0;
        cyc(3);
        chk(oneshot_active_o, 16'h0001);
        roll();
        cyc(3);
        roll();
        cyc(3);
        chk(oneshot_active_o, 16'h0001);
        roll();
        cyc(3);
        chk(oneshot_active_o, 16'h0000);
        final_report();
    end
endmodule // ccos_top_test
bind ccos_top ccos_checker i_chk (.*);
